// ==== scc_checker_sva.sv ====
// Purpose: Port-level checks on the SPI command checker
// Assumes: One clock domain, synchronous active-high reset
// Notes: Windows allow for the two-stage pin synchronisers
module scc_checker_sva (
    input wire sys_clk_in,
    input wire rst_in,
    input wire select_n_pin_in,
    input wire reset_output_pin_in,
    input wire serial_out_pin_out,
    input wire serial_out_pin_oe_out,
    input wire host_int_out,
    input wire [2:0] mode_out,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr
);
    // Write to the control word that may leave restart
    wire ctrl_wr = psel && penable && pwrite && (paddr == 8'h04);

    // Every check shares the one clock and reset
    default clocking dflt_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    oe_drop_a:
    assert property (select_n_pin_in [*5] |-> !serial_out_pin_oe_out)
        else $error("output enable held after select release");
    oe_drive_a:
    assert property (!select_n_pin_in [*5] |-> serial_out_pin_oe_out)
        else $error("output not driven during frame");
    ro_high_a:
    assert property ((!reset_output_pin_in && !select_n_pin_in) [*6]
        |-> serial_out_pin_out)
        else $error("serial output low while reset output low");
    int_pulse_a:
    assert property (host_int_out |=> !host_int_out && mode_out == 3'h2)
        else $error("interrupt not a single pulse on stop entry");
    mode_hold_a:
    assert property (!select_n_pin_in [*5] |=> $stable(mode_out))
        else $error("mode changed inside a frame");
    restart_hold_a:
    assert property ($fell(mode_out == 3'h4)
        |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("restart left without control write");
    init_exit_a:
    assert property ($past(mode_out) == 3'h0
        |-> mode_out != 3'h2 && mode_out != 3'h3)
        else $error("init went straight to a low-power mode");
    stop_exit_a:
    assert property ($past(mode_out) == 3'h2 |-> mode_out != 3'h3)
        else $error("stop went straight to sleep");
    apb_wait_a:
    assert property (psel && penable && !pready |=> pready)
        else $error("bus answer not after one wait state");
    apb_err_a:
    assert property (pready |-> pslverr == (paddr != 8'h00
        && paddr != 8'h04 && paddr != 8'h08))
        else $error("bus error flag wrong for offset");
endmodule // scc_checker_sva

bind scc_spi_checker scc_checker_sva chk_u (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .select_n_pin_in(select_n_pin_in),
    .reset_output_pin_in(reset_output_pin_in),
    .serial_out_pin_out(serial_out_pin_out),
    .serial_out_pin_oe_out(serial_out_pin_oe_out),
    .host_int_out(host_int_out), .mode_out(mode_out), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr)
);

// ==== scc_host_model.sv ====
// Purpose: Host microcontroller acting as SPI master
// Assumes: Link clock of 800 ns, eight system clocks
// Notes: Clock stands low between frames
module scc_host_model (
    input wire logic sys_clk_in,
    input wire logic serial_out_pin_in,
    output logic spi_clk_out,
    output logic select_n_pin_out,
    output logic serial_in_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pins at time zero
    initial
    begin
        spi_clk_out = 1'b0;
        select_n_pin_out = 1'b1;
        serial_in_pin_out = 1'b0;
    end

    // Pins move just after an edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    // One frame of n clocks, word LSB first; hi puts clock high at select
    task automatic frame(input logic [15:0] w, input int n,
                         input logic hi, output logic [15:0] rx);
        rx = 16'h0000;
        tick(1);
        spi_clk_out <= hi;
        tick(1);
        select_n_pin_out <= 1'b0;
        tick(2);
        spi_clk_out <= 1'b0;
        tick(6);
        // Data moves with the rising clock, so it is stable at the fall
        for (int i = 0; i < n; i++)
        begin
            tick(4);
            if (i < 16)
                rx[i] = serial_out_pin_in; // Settled since last rise
            spi_clk_out <= 1'b1;
            serial_in_pin_out <= w[i % 16];
            tick(4);
            spi_clk_out <= 1'b0;
        end
        tick(4);
        spi_clk_out <= hi;
        tick(1);
        select_n_pin_out <= 1'b1;
        tick(1);
        spi_clk_out <= 1'b0;
        serial_in_pin_out <= ~serial_in_pin_out; // Released line drifts
        tick(8);
    endtask
endmodule // scc_host_model

// ==== scc_map.vh ====
// Purpose: Constants for the SPI command checker
// Assumes: 16-bit command word, APB with 32-bit data
// Notes: Command field positions, register addresses, mode codes
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// Command word fields
`define SCC_WORD_BITS 16
`define SCC_CNT_BITS 5
`define SCC_ADDR_MSB 6
`define SCC_WR_BIT 7
`define SCC_DATA_LSB 8
`define SCC_DATA_MSB 15

// Register addresses inside the command word
`define SCC_A_MODE_CTRL 7'h01
`define SCC_A_WATCHDOG_CONTROL_REG 7'h03
`define SCC_A_BUS_CTRL_1 7'h04
`define SCC_A_BUS_CTRL_2 7'h05
`define SCC_A_WAKE_CTRL_2 7'h06
`define SCC_A_TIMER_CTRL 7'h0C
`define SCC_A_DEV_STAT 7'h43
`define SCC_A_WAKE_STAT_1 7'h46
`define SCC_A_WAKE_STAT_2 7'h47

// Mode request field in the mode control data byte
`define SCC_MREQ_MSB 7
`define SCC_MREQ_LSB 6
`define SCC_MREQ_NORMAL 2'h0
`define SCC_MREQ_SLEEP 2'h1
`define SCC_MREQ_STOP 2'h2
`define SCC_MREQ_SOFT_RST 2'h3
`define SCC_LOAD_SHARE_BIT 2

// Wake control two fields
`define SCC_WK_IN1_BIT 0
`define SCC_WK_IN2_BIT 1
`define SCC_WK_TIMER_BIT 2
`define SCC_WAKE_PIN_MEASURE_MODE_BIT 7

// Device status clear bit for the reject flag
`define SCC_REJ_BIT 0

// Timer control fields: period low nibble, on-time high nibble
`define SCC_TMR_OFF 4'h0

// APB byte offsets
`define SCC_APB_STATUS 8'h00
`define SCC_APB_CTRL 8'h04
`define SCC_APB_LAST 8'h08
`define SCC_CTRL_LEAVE_RST_BIT 0

`endif

// ==== scc_spi_checker.v ====
// Purpose: 16-bit SPI command port with command and frame checking
// Assumes: SPI pins and wake inputs are asynchronous to sys_clk_in;
//          link clock at least 8 system clocks per period
// Notes: Word is received LSB first; output word bit 0 is the
//        frame error bit, driven as soon as select falls
`include "scc_map.vh"

// How it works
// R1: Receive one 16-bit word per frame
// R2: Select falling starts a frame
// R3: Select rising interprets word, releases output
// R4: Sample on falling clock, shift on rising
// R5: Wrong command ignored, reject flag set
// R6: Reject flag cleared only by clear command
// R7: Stop to Sleep rejected, enter Restart
// R8: Stop or Sleep from Init rejected, Normal
// R9: Watchdog byte with odd parity discarded, rejected
// R10: Stop mode accepts only few commands
// R11: Stop with pending wake status pulses interrupt
// R12: Stop to Normal applies only mode change
// R13: Sleep without wake source: reject, Restart, rest
// R14: Only timer source and timer off: Restart
// R15: Stop without wake sources is accepted
// R16: Load sharing stays set once enabled
// R17: Sleep with measurement and pin-only wake rejected
// R18: Timer on-time not below period rejected
// R19: All-zero or all-one frame rejected
// R20: Unused addresses never set reject flag
// R21: Clock count not 0 or 16 flags frame error
// R22: Frames while reset output low flag error
// R23: Frame error shown high before first rising edge
// R24: Host keeps clock low at select fall
// R25: Address low seven bits, bit7 write, data high
// R26: No command interpreted during Restart
// R27: Reset output low drives serial output high
// R28: Counter and shifter cleared at select fall
module scc_spi_checker (
    input wire sys_clk_in,
    input wire rst_in,
    input wire spi_clk_in,
    input wire select_n_pin_in,
    input wire serial_in_pin_in,
    input wire reset_output_pin_in,
    input wire [1:0] wake_event_in,
    output reg serial_out_pin_out,
    output reg serial_out_pin_oe_out,
    output reg host_int_out,
    output reg [2:0] mode_out,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);

// Device modes
localparam MODE_INIT = 3'h0;
localparam MODE_NORMAL = 3'h1;
localparam MODE_STOP = 3'h2;
localparam MODE_SLEEP = 3'h3;
localparam MODE_RESTART = 3'h4;

wire [5:0] pins;
wire sclk = pins[0];
wire sel_n = pins[1];
wire serial_in_pin = pins[2];
wire ro_hi = pins[3];
wire [1:0] wake = pins[5:4];

reg sclk_d;
reg sel_n_d;
reg [`SCC_CNT_BITS-1:0] cnt;
reg [15:0] shift;
reg [15:0] out_sr;
reg clk_hi_edge;
reg ro_low_seen;
reg frame_err;
reg cmd_reject;
reg [7:0] mctrl;
reg [7:0] watchdog_control_reg;
reg [7:0] bus1;
reg [7:0] bus2;
reg [7:0] wk2;
reg [7:0] tmr;
reg [7:0] wk_stat1;
reg [7:0] wk_stat2;
reg [15:0] last_cmd;
reg leave_rst;

// Pin sampling: select and reset output start high, no false edge
scc_sync #(.WIDTH(6), .RST_VAL(6'h0A)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in({wake_event_in, reset_output_pin_in, serial_in_pin_in,
        select_n_pin_in, spi_clk_in}),
    .sync_out(pins)
);

wire sclk_rise = sclk & ~sclk_d;
wire sclk_fall = ~sclk & sclk_d;
wire frame_start = ~sel_n & sel_n_d;
wire frame_end = sel_n & ~sel_n_d;

// Command fields of the received word
wire [6:0] c_addr = shift[`SCC_ADDR_MSB:0]; // [R25]
wire c_wr = shift[`SCC_WR_BIT];
wire [7:0] c_data = shift[`SCC_DATA_MSB:`SCC_DATA_LSB];
wire [1:0] c_req = c_data[`SCC_MREQ_MSB:`SCC_MREQ_LSB];

// Wake source summary
wire bus_off = (bus1 == 8'h00) && (bus2 == 8'h00);
wire no_source = bus_off && (wk2 == 8'h00);
wire pins_only = bus_off && !wk2[`SCC_WK_TIMER_BIT] &&
    (wk2[`SCC_WK_IN1_BIT] || wk2[`SCC_WK_IN2_BIT]);
wire timer_only = bus_off && wk2[`SCC_WK_TIMER_BIT] &&
    !wk2[`SCC_WK_IN1_BIT] && !wk2[`SCC_WK_IN2_BIT];
wire timer_off = (tmr[3:0] == `SCC_TMR_OFF);
wire wake_pending = (wk_stat1 != 8'h00) || (wk_stat2 != 8'h00);

reg [2:0] next_mode;
reg [7:0] next_mctrl;
reg [7:0] next_watchdog_control_reg;
reg [7:0] next_bus1;
reg [7:0] next_bus2;
reg [7:0] next_wk2;
reg [7:0] next_tmr;
reg [7:0] clr_stat1;
reg [7:0] clr_stat2;
reg rej_set;
reg rej_clr;
reg ferr_set;
reg int_set;

// Interpretation of a finished frame
always @*
begin
    next_mode = mode_out;
    next_mctrl = mctrl;
    next_watchdog_control_reg = watchdog_control_reg;
    next_bus1 = bus1;
    next_bus2 = bus2;
    next_wk2 = wk2;
    next_tmr = tmr;
    clr_stat1 = 8'h00;
    clr_stat2 = 8'h00;
    rej_set = 1'b0;
    rej_clr = 1'b0;
    ferr_set = 1'b0;
    int_set = 1'b0;
    if (frame_end)
    begin
        // Bad clock count, clock high at an edge, or reset low
        if (clk_hi_edge || sclk || ro_low_seen || !ro_hi ||
            (cnt != 5'h00 && cnt != 5'h10))
        begin
            ferr_set = 1'b1; // [R21] [R22]
        end
        else if (cnt == 5'h10 && mode_out != MODE_RESTART) // [R26]
        begin
            if (shift == 16'h0000 || shift == 16'hFFFF)
            begin
                rej_set = 1'b1; // [R19]
            end
            else if (c_wr)
            begin
                case (c_addr)
                `SCC_A_MODE_CTRL:
                begin
                    if (mode_out == MODE_STOP)
                    begin
                        // Only the mode change is taken [R12]
                        if (c_req == `SCC_MREQ_NORMAL)
                        begin
                            next_mode = MODE_NORMAL;
                        end
                        else if (c_req == `SCC_MREQ_SOFT_RST)
                        begin
                            next_mode = MODE_RESTART;
                        end
                        else if (c_req == `SCC_MREQ_SLEEP)
                        begin
                            rej_set = 1'b1; // [R7]
                            next_mode = MODE_RESTART;
                        end
                        else
                        begin
                            rej_set = 1'b1; // [R10]
                        end
                    end
                    else if (mode_out == MODE_INIT &&
                        (c_req == `SCC_MREQ_STOP ||
                        c_req == `SCC_MREQ_SLEEP))
                    begin
                        rej_set = 1'b1; // [R8]
                        next_mode = MODE_NORMAL;
                    end
                    else
                    begin
                        // Load share can be set but not cleared [R16]
                        next_mctrl = c_data;
                        next_mctrl[`SCC_LOAD_SHARE_BIT] =
                            c_data[`SCC_LOAD_SHARE_BIT] |
                            mctrl[`SCC_LOAD_SHARE_BIT];
                        case (c_req)
                        `SCC_MREQ_SLEEP:
                        begin
                            // Rest of command still stored [R13]
                            if (no_source ||
                                (wk2[`SCC_WAKE_PIN_MEASURE_MODE_BIT] && pins_only))
                            begin
                                rej_set = 1'b1; // [R13] [R17]
                                next_mode = MODE_RESTART;
                            end
                            else
                            begin
                                next_mode = MODE_SLEEP;
                            end
                        end
                        `SCC_MREQ_STOP:
                        begin
                            // No wake source is fine here [R15]
                            next_mode = MODE_STOP;
                            int_set = wake_pending; // [R11]
                        end
                        `SCC_MREQ_SOFT_RST:
                        begin
                            next_mode = MODE_RESTART;
                        end
                        default:
                        begin
                            next_mode = MODE_NORMAL;
                        end
                        endcase
                    end
                end
                `SCC_A_WATCHDOG_CONTROL_REG:
                begin
                    // Trigger or settings dropped on odd parity
                    if (^c_data)
                    begin
                        rej_set = 1'b1; // [R9]
                    end
                    else
                    begin
                        next_watchdog_control_reg = c_data;
                    end
                end
                `SCC_A_BUS_CTRL_1, `SCC_A_BUS_CTRL_2,
                `SCC_A_WAKE_CTRL_2, `SCC_A_TIMER_CTRL:
                begin
                    if (mode_out == MODE_STOP)
                    begin
                        rej_set = 1'b1; // [R10] [R5]
                    end
                    else if (c_addr == `SCC_A_BUS_CTRL_1)
                    begin
                        next_bus1 = c_data;
                    end
                    else if (c_addr == `SCC_A_BUS_CTRL_2)
                    begin
                        next_bus2 = c_data;
                    end
                    else if (c_addr == `SCC_A_WAKE_CTRL_2)
                    begin
                        next_wk2 = c_data;
                    end
                    else if (c_data[7:4] >= c_data[3:0] &&
                        c_data[3:0] != `SCC_TMR_OFF)
                    begin
                        rej_set = 1'b1; // [R18]
                    end
                    else
                    begin
                        next_tmr = c_data;
                    end
                end
                `SCC_A_DEV_STAT:
                begin
                    rej_clr = c_data[`SCC_REJ_BIT]; // [R6]
                end
                `SCC_A_WAKE_STAT_1:
                begin
                    clr_stat1 = c_data;
                end
                `SCC_A_WAKE_STAT_2:
                begin
                    clr_stat2 = c_data;
                end
                default:
                begin
                    // Unused address: silently ignored [R20]
                    rej_set = 1'b0;
                end
                endcase
            end
        end
    end
    else if (mode_out == MODE_SLEEP && ((wake != 2'h0) ||
        (timer_only && timer_off)))
    begin
        next_mode = MODE_RESTART; // [R14]
    end
    else if (mode_out == MODE_RESTART && leave_rst)
    begin
        next_mode = MODE_NORMAL;
    end
end

// Receive path and per-frame error capture
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        sclk_d <= 1'b0;
        sel_n_d <= 1'b1;
        cnt <= 5'h00;
        shift <= 16'h0000;
        clk_hi_edge <= 1'b0;
        ro_low_seen <= 1'b0;
    end
    else
    begin
        sclk_d <= sclk;
        sel_n_d <= sel_n;
        if (frame_start)
        begin
            // Fresh frame, history dropped [R2] [R28]
            cnt <= 5'h00;
            shift <= 16'h0000;
            clk_hi_edge <= sclk; // [R24]
            ro_low_seen <= ~ro_hi;
        end
        else if (!sel_n)
        begin
            if (sclk_fall)
            begin
                // LSB first; count saturates to stay illegal
                shift <= {serial_in_pin, shift[15:1]}; // [R1] [R4]
                if (cnt != 5'h1F)
                begin
                    cnt <= cnt + 5'h01; // [R21]
                end
            end
            if (!ro_hi)
            begin
                ro_low_seen <= 1'b1; // [R22]
            end
        end
    end
end

// Output path: error bit first, tristate when deselected
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        out_sr <= 16'h0000;
        serial_out_pin_out <= 1'b0;
        serial_out_pin_oe_out <= 1'b0;
    end
    else
    begin
        if (frame_start)
        begin
            out_sr <= {mctrl, 2'h0, wake_pending, mode_out,
                cmd_reject, frame_err}; // [R23]
        end
        else if (!sel_n && sclk_rise)
        begin
            out_sr <= {1'b0, out_sr[15:1]}; // [R4]
        end
        serial_out_pin_oe_out <= ~sel_n & ~frame_end; // [R3]
        if (!ro_hi)
        begin
            serial_out_pin_out <= 1'b1; // [R27]
        end
        else if (frame_start)
        begin
            serial_out_pin_out <= frame_err; // [R23]
        end
        else
        begin
            serial_out_pin_out <= out_sr[0];
        end
    end
end

// Command state; a set beats a clear in the same cycle
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        mode_out <= MODE_INIT;
        mctrl <= 8'h00;
        watchdog_control_reg <= 8'h00;
        bus1 <= 8'h00;
        bus2 <= 8'h00;
        wk2 <= 8'h00;
        tmr <= 8'h00;
        wk_stat1 <= 8'h00;
        wk_stat2 <= 8'h00;
        cmd_reject <= 1'b0;
        frame_err <= 1'b0;
        host_int_out <= 1'b0;
        last_cmd <= 16'h0000;
    end
    else
    begin
        mode_out <= next_mode; // [R3]
        mctrl <= next_mctrl;
        watchdog_control_reg <= next_watchdog_control_reg;
        bus1 <= next_bus1;
        bus2 <= next_bus2;
        wk2 <= next_wk2;
        tmr <= next_tmr;
        wk_stat1 <= (wk_stat1 & ~clr_stat1) | {7'h00, wake[0]};
        wk_stat2 <= (wk_stat2 & ~clr_stat2) | {7'h00, wake[1]};
        cmd_reject <= (cmd_reject & ~rej_clr) | rej_set; // [R5] [R6]
        // Shown once at next select fall, then dropped
        if (ferr_set)
        begin
            frame_err <= 1'b1; // [R21]
        end
        else if (frame_start)
        begin
            frame_err <= 1'b0;
        end
        host_int_out <= int_set; // [R11]
        if (frame_end && !ferr_set && cnt == 5'h10)
        begin
            last_cmd <= shift;
        end
    end
end

// APB slave: one wait state, error on unmapped offsets
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        leave_rst <= 1'b0;
    end
    else
    begin
        pready <= psel & penable & ~pready;
        pslverr <= 1'b0;
        leave_rst <= 1'b0;
        if (psel && penable && !pready)
        begin
            prdata <= 32'h00000000;
            case (paddr)
            `SCC_APB_STATUS:
            begin
                prdata <= {16'h0000, mctrl, 1'b0, wake_pending,
                    mode_out, 1'b0, cmd_reject, frame_err};
            end
            `SCC_APB_CTRL:
            begin
                // Write one releases the device from Restart
                leave_rst <= pwrite & pwdata[`SCC_CTRL_LEAVE_RST_BIT];
            end
            `SCC_APB_LAST:
            begin
                prdata <= {16'h0000, last_cmd};
            end
            default:
            begin
                pslverr <= 1'b1;
            end
            endcase
        end
    end
end

endmodule // scc_spi_checker

// ==== scc_sync.v ====
// Purpose: Two flip-flop synchroniser for a group of pin inputs
// Assumes: Each bit is an independent level
// Notes: Only the second stage may be read by other logic
module scc_sync #(
    parameter WIDTH = 6,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// First stage feeds the second stage only; reset to idle pin levels
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        meta <= RST_VAL;
        sync_out <= RST_VAL;
    end
    else
    begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule // scc_sync

// ==== tb.sv ====
// Purpose: Self-checking bench for the SPI command checker
// Assumes: Host model paces the link, bench drives APB
// Notes: Each go call sends a frame, then reads status over APB
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in, rst_in, spi_clk_in, select_n_pin_in;
    logic serial_in_pin_in, reset_output_pin_in;
    logic [1:0] wake_event_in;
    logic serial_out_pin_out, serial_out_pin_oe_out, host_int_out;
    logic [2:0] mode_out;
    logic psel, penable, pwrite, pready, pslverr, bus_err, int_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rx;
    int cnt[4] = '{15, 17, 16, 0};
    int error_cnt = 0;
    int cmp_count = 0;

    scc_spi_checker dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .spi_clk_in(spi_clk_in), .select_n_pin_in(select_n_pin_in),
        .serial_in_pin_in(serial_in_pin_in),
        .reset_output_pin_in(reset_output_pin_in),
        .wake_event_in(wake_event_in),
        .serial_out_pin_out(serial_out_pin_out),
        .serial_out_pin_oe_out(serial_out_pin_oe_out),
        .host_int_out(host_int_out), .mode_out(mode_out), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    scc_host_model host_u (.sys_clk_in(sys_clk_in),
        .serial_out_pin_in(serial_out_pin_oe_out ? serial_out_pin_out :
            ~serial_out_pin_out), .spi_clk_out(spi_clk_in),
        .select_n_pin_out(select_n_pin_in),
        .serial_in_pin_out(serial_in_pin_in));

    // 10 MHz system clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    // Latch the one-cycle interrupt pulse
    always @(posedge sys_clk_in)
        if (host_int_out === 1'b1)
            int_seen <= 1'b1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // APB transfer; waits for pready, bounded
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            error_cnt++;
        rd = prdata;
        bus_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reset_dut;
        rst_in <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask

    // Send a command, check mode and reject flag, then tidy up
    task automatic go(input logic [15:0] w, input logic [2:0] m,
                      input logic r);
        host_u.frame(w, 16, 1'b0, rx);
        apb(1'b0, 8'h00, 32'h0);
        chk({rd[5:3], rd[1]}, {m, r});
        if (m == 3'h4)
            apb(1'b1, 8'h04, 32'h1);
        if (r)
            host_u.frame(16'h01C3, 16, 1'b0, rx);
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial
    begin
        #4_000_000;
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        rst_in = 1'b1;
        reset_output_pin_in = 1'b1;
        wake_event_in = 2'b00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        int_seen = 1'b0;
        reset_dut();
        chk(mode_out, 3'h0);
        go(16'h4081, 3'h1, 1'b1);
        reset_dut();
        go(16'h8081, 3'h1, 1'b1);
        host_u.frame(16'hFFFF, 16, 1'b0, rx);
        go(16'h0003, 3'h1, 1'b1);
        go(16'h0003, 3'h1, 1'b0);
        go(16'h0000, 3'h1, 1'b1);
        go(16'h5590, 3'h1, 1'b0);
        go(16'h0183, 3'h1, 1'b1);
        go(16'h0383, 3'h1, 1'b0);
        go(16'h328C, 3'h1, 1'b1);
        go(16'h338C, 3'h1, 1'b1);
        go(16'h238C, 3'h1, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_238C);
        go(16'h0481, 3'h1, 1'b0);
        go(16'h0081, 3'h1, 1'b0);
        chk(rd[10], 1'b1);
        go(16'h8081, 3'h2, 1'b0);
        go(16'h238C, 3'h2, 1'b1);
        go(16'h0881, 3'h1, 1'b0);
        chk(rd[11], 1'b0);
        go(16'h8081, 3'h2, 1'b0);
        host_u.frame(16'h4081, 16, 1'b0, rx);
        host_u.frame(16'h0081, 16, 1'b0, rx);
        chk(mode_out, 3'h4);
        go(16'h0003, 3'h4, 1'b1);
        go(16'h4081, 3'h4, 1'b1);
        go(16'h8386, 3'h1, 1'b0);
        go(16'h4081, 3'h4, 1'b1);
        go(16'h0486, 3'h1, 1'b0);
        go(16'h008C, 3'h1, 1'b0);
        go(16'h4081, 3'h4, 1'b0);
        wake_event_in <= 2'b11;
        repeat (4) @(posedge sys_clk_in);
        wake_event_in <= 2'b00;
        int_seen <= 1'b0;
        go(16'h8081, 3'h2, 1'b0);
        chk({rd[6], int_seen}, 2'b11);
        go(16'h01C6, 3'h2, 1'b0);
        go(16'h01C7, 3'h2, 1'b0);
        chk(rd[6], 1'b0);
        go(16'hC081, 3'h4, 1'b0);
        go(16'h0081, 3'h1, 1'b0);
        // Bad clock counts and clock high at select, then 0 clocks
        for (int k = 0; k < 4; k++)
        begin
            host_u.frame(16'h8081, cnt[k], k == 2, rx);
            host_u.frame(16'h0003, 16, 1'b0, rx);
            chk({mode_out, rx[4:0]}, {6'h09, 1'b0, k < 3});
        end
        reset_output_pin_in <= 1'b0;
        host_u.frame(16'h0003, 16, 1'b0, rx);
        chk(rx, 16'hFFFF);
        reset_output_pin_in <= 1'b1;
        host_u.frame(16'h0003, 16, 1'b0, rx);
        chk(rx[0], 1'b1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(bus_err, 1'b1);
        report_and_stop();
    end
endmodule // tb
